// file: src/supply_monitor_params.svh
// Constants for the supply low-voltage monitor
`ifndef SUPPLY_MONITOR_PARAMS_SVH
`define SUPPLY_MONITOR_PARAMS_SVH
`define SM_ADDR_CTRL 4'h0
`define SM_ADDR_STATUS 4'h4
`define SM_ADDR_MASK 4'h8
`define SM_LEVEL_LSB 0
`define SM_REFEN_BIT 3
`define SM_DETEN_BIT 4
`define SM_OUT_BIT 5
`define SM_WIDTH_LSB 6
`define SM_CTRL_RESET 8'h00
`define SM_CTRL_WMASK 8'hDF
`define SM_SUB_HZ 32768
`define SM_CLK_HZ 200000000
`define SM_SUB_DIV (`SM_CLK_HZ / `SM_SUB_HZ)
`define SM_QUAL_W0 3'h1
`define SM_QUAL_W1 3'h3
`define SM_QUAL_W2 3'h7
`endif

// file: src/supply_monitor_pkg.sv
// Types for the supply low-voltage monitor
package supply_monitor_pkg;
    typedef struct packed {
        logic [1:0] qualify_width_select;
        logic low_supply_output_flag;
        logic detector_enable;
        logic reference_enable;
        logic [2:0] trip_level_select;
    } ctrl_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WRITE = 2'b01,
        ST_READ = 2'b10
    } bus_state_t;
endpackage : supply_monitor_pkg

// file: src/sub_tick_divider.sv
// Divider that makes the sub-clock enable pulse
`timescale 1ns/1ps
module sub_tick_divider #(
    parameter int DIV = 6103
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Tick
    output logic tick_o
);
    typedef struct packed {
        logic [15:0] cnt;
        logic tick;
    } div_state_t;
    div_state_t s_reg;
    div_state_t s_next;
    always_comb
    begin
        s_next = s_reg;
        s_next.tick = 1'b0;
        if (s_reg.cnt == 16'(DIV - 1))
        begin
            s_next.cnt = 16'h0000;
            s_next.tick = 1'b1;
        end
        else
        begin
            s_next.cnt = s_reg.cnt + 16'h0001;
        end
    end
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s_reg <= '0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end
    assign tick_o = s_reg.tick;
endmodule : sub_tick_divider

// file: src/supply_low_voltage_monitor.sv
// Control and status logic of the supply low-voltage detector
`timescale 1ns/1ps
`include "supply_monitor_params.svh"
module supply_low_voltage_monitor
    import supply_monitor_pkg::*;
#(
    parameter int SUB_DIV = `SM_SUB_DIV
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Avalon-MM slave
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Analog side
    input wire logic comparator_low_i,
    input wire logic low_supply_reset_enable_i,
    input wire logic sleep_i,
    input wire logic idle_i,
    output logic detector_power_o,
    output logic [2:0] trip_level_o,
    output logic reference_request_o,
    // Interrupt and wake
    output logic irq_o,
    output logic wake_o
);
    typedef struct packed {
        ctrl_t ctrl;
        logic irq_flag;
        logic irq_enable;
        logic [2:0] qual_cnt;
        logic wake;
        bus_state_t bus;
        logic [31:0] rdata;
    } mon_state_t;

    mon_state_t s_reg;
    mon_state_t s_next;
    logic [1:0] rst_sync_reg;
    logic rst_n;
    logic sub_tick;
    logic det_on;
    logic [2:0] qual_target;
    logic qualified;
    logic wr_hit;
    logic [31:0] rd_mux;

    // Reset release through two flip-flops
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rst_sync_reg <= 2'b00;
        end
        else
        begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    sub_tick_divider #(
        .DIV(SUB_DIV)
    ) u_div (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .tick_o(sub_tick)
    );

    // Detector runs only when enabled and not sleeping
    assign det_on = s_reg.ctrl.detector_enable && !sleep_i;
    assign detector_power_o = det_on;
    assign trip_level_o = s_reg.ctrl.trip_level_select;
    assign reference_request_o = det_on || low_supply_reset_enable_i
        || s_reg.ctrl.reference_enable;

    // Width selection in sub periods
    always_comb
    begin
        unique case (s_reg.ctrl.qualify_width_select)
            2'b00: qual_target = `SM_QUAL_W0;
            2'b01: qual_target = `SM_QUAL_W1;
            2'b10: qual_target = `SM_QUAL_W2;
            2'b11: qual_target = `SM_QUAL_W0;
        endcase
    end
    assign qualified = s_reg.ctrl.low_supply_output_flag && sub_tick
        && (s_reg.qual_cnt >= qual_target);
    assign wr_hit = s_reg.bus == ST_WRITE;

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        unique case (avs_address_i)
            `SM_ADDR_CTRL: rd_mux = {24'h000000, s_reg.ctrl};
            `SM_ADDR_STATUS: rd_mux = {31'h0, s_reg.irq_flag};
            `SM_ADDR_MASK: rd_mux = {31'h0, s_reg.irq_enable};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_comb
    begin
        s_next = s_reg;
        s_next.wake = 1'b0;
        // Output flag follows comparator while powered
        s_next.ctrl.low_supply_output_flag = det_on && comparator_low_i;
        // Width counter on sub ticks, restarts when flag drops
        if (!s_reg.ctrl.low_supply_output_flag)
        begin
            s_next.qual_cnt = 3'h0;
        end
        else if (sub_tick && s_reg.qual_cnt != 3'h7)
        begin
            s_next.qual_cnt = s_reg.qual_cnt + 3'h1;
        end
        // Bus transfers
        unique case (s_reg.bus)
            ST_IDLE:
            begin
                if (avs_write_i)
                begin
                    s_next.bus = ST_WRITE;
                end
                else if (avs_read_i)
                begin
                    s_next.bus = ST_READ;
                    s_next.rdata = rd_mux;
                end
            end
            ST_WRITE, ST_READ: s_next.bus = ST_IDLE;
            default: s_next.bus = ST_IDLE;
        endcase
        if (wr_hit && avs_byteenable_i[0])
        begin
            unique case (avs_address_i)
                `SM_ADDR_CTRL:
                begin
                    s_next.ctrl = (avs_writedata_i[7:0] & `SM_CTRL_WMASK)
                        | (s_next.ctrl & ~`SM_CTRL_WMASK);
                end
                `SM_ADDR_STATUS:
                begin
                    // Write one clears the flag
                    if (avs_writedata_i[0])
                    begin
                        s_next.irq_flag = 1'b0;
                    end
                end
                `SM_ADDR_MASK: s_next.irq_enable = avs_writedata_i[0];
                default:
                begin
                end
            endcase
        end
        // Event set wins over clear
        if (qualified)
        begin
            s_next.irq_flag = 1'b1;
            s_next.wake = !s_reg.irq_flag && idle_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_reg.ctrl <= `SM_CTRL_RESET;
            s_reg.irq_flag <= 1'b0;
            s_reg.irq_enable <= 1'b0;
            s_reg.qual_cnt <= 3'h0;
            s_reg.wake <= 1'b0;
            s_reg.bus <= ST_IDLE;
            s_reg.rdata <= 32'h0000_0000;
        end
        else
        begin
            s_reg.ctrl <= s_next.ctrl;
            s_reg.irq_flag <= s_next.irq_flag;
            s_reg.irq_enable <= s_next.irq_enable;
            s_reg.qual_cnt <= s_next.qual_cnt;
            s_reg.wake <= s_next.wake;
            s_reg.bus <= s_next.bus;
            s_reg.rdata <= s_next.rdata;
        end
    end

    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && s_reg.bus == ST_IDLE;
    assign avs_readdata_o = s_reg.rdata;
    assign irq_o = s_reg.irq_flag && s_reg.irq_enable;
    assign wake_o = s_reg.wake;

    a_sleep_forces_off: assert property (@(posedge clk_i) disable iff (!rst_n)
        sleep_i |-> !detector_power_o) else $error("detector on in sleep");
    a_ref_request: assert property (@(posedge clk_i) disable iff (!rst_n)
        s_reg.ctrl.reference_enable |-> reference_request_o)
        else $error("reference not requested");
    a_flag_off_when_disabled: assert property (@(posedge clk_i) disable iff (!rst_n)
        !det_on |=> !s_reg.ctrl.low_supply_output_flag)
        else $error("output flag set while detector off");
    a_flag_follows: assert property (@(posedge clk_i) disable iff (!rst_n)
        (det_on && comparator_low_i) |=> s_reg.ctrl.low_supply_output_flag)
        else $error("output flag missed low supply");
    a_cnt_restart: assert property (@(posedge clk_i) disable iff (!rst_n)
        !s_reg.ctrl.low_supply_output_flag |=> s_reg.qual_cnt == 3'h0)
        else $error("width counter not restarted");
    a_irq_needs_width: assert property (@(posedge clk_i) disable iff (!rst_n)
        ($rose(s_reg.irq_flag)) |-> $past(s_reg.qual_cnt) >= $past(qual_target))
        else $error("irq flag set before width");
    a_irq_sticky: assert property (@(posedge clk_i) disable iff (!rst_n)
        (s_reg.irq_flag && !wr_hit) |=> s_reg.irq_flag)
        else $error("irq flag dropped without clear");
    a_irq_gated: assert property (@(posedge clk_i) disable iff (!rst_n)
        irq_o == (s_reg.irq_flag && s_reg.irq_enable))
        else $error("irq output not gated by enable");
    a_wake_on_new: assert property (@(posedge clk_i) disable iff (!rst_n)
        wake_o |-> s_reg.irq_flag && !$past(s_reg.irq_flag))
        else $error("wake without new flag");
    a_trip_level: assert property (@(posedge clk_i) disable iff (!rst_n)
        trip_level_o == s_reg.ctrl.trip_level_select)
        else $error("trip level mismatch");

    // Sub ticks seen while the output flag stays high, for the width checks
    logic [3:0] chk_ticks_reg;
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            chk_ticks_reg <= 4'h0;
        end
        else if (!s_reg.ctrl.low_supply_output_flag)
        begin
            chk_ticks_reg <= 4'h0;
        end
        else if (sub_tick && chk_ticks_reg != 4'hF)
        begin
            chk_ticks_reg <= chk_ticks_reg + 4'h1;
        end
    end

    // Width checks
    a_irq_in_time: assert property (@(posedge clk_i) disable iff (!rst_n)
        (s_reg.ctrl.low_supply_output_flag && sub_tick
        && chk_ticks_reg >= {1'b0, qual_target}) |=> s_reg.irq_flag)
        else $error("irq flag late after width");
    a_irq_min_ticks: assert property (@(posedge clk_i) disable iff (!rst_n)
        $rose(s_reg.irq_flag)
        |-> $past(chk_ticks_reg) >= {1'b0, $past(qual_target)})
        else $error("irq flag before minimum width");

    // Bus checks
    a_wait_first: assert property (@(posedge clk_i) disable iff (!rst_n)
        ((avs_read_i || avs_write_i) && s_reg.bus == ST_IDLE)
        |-> avs_waitrequest_o)
        else $error("waitrequest low in first cycle");
    a_wait_second: assert property (@(posedge clk_i) disable iff (!rst_n)
        ((avs_read_i || avs_write_i) && s_reg.bus == ST_IDLE)
        |=> !avs_waitrequest_o)
        else $error("waitrequest high in second cycle");
    a_bus_returns: assert property (@(posedge clk_i) disable iff (!rst_n)
        (s_reg.bus != ST_IDLE)
        |=> s_reg.bus == ST_IDLE)
        else $error("bus did not return to idle");
    a_read_status: assert property (@(posedge clk_i) disable iff (!rst_n)
        (avs_read_i && s_reg.bus == ST_IDLE && avs_address_i == `SM_ADDR_STATUS)
        |=> avs_readdata_o == {31'h0, $past(s_reg.irq_flag)})
        else $error("status read data wrong");
    a_ctrl_write: assert property (@(posedge clk_i) disable iff (!rst_n)
        (wr_hit && avs_byteenable_i[0] && avs_address_i == `SM_ADDR_CTRL)
        |=> s_reg.ctrl.trip_level_select == $past(avs_writedata_i[2:0]))
        else $error("control write lost");

    // Detector and reference checks
    a_det_off: assert property (@(posedge clk_i) disable iff (!rst_n)
        !s_reg.ctrl.detector_enable
        |-> !detector_power_o)
        else $error("detector powered while disabled");
    a_ref_from_lsr: assert property (@(posedge clk_i) disable iff (!rst_n)
        low_supply_reset_enable_i
        |-> reference_request_o)
        else $error("reference not requested for reset");
    a_ref_from_det: assert property (@(posedge clk_i) disable iff (!rst_n)
        detector_power_o
        |-> reference_request_o)
        else $error("reference not requested for detector");
    a_ref_none: assert property (@(posedge clk_i) disable iff (!rst_n)
        (!detector_power_o && !low_supply_reset_enable_i && !s_reg.ctrl.reference_enable)
        |-> !reference_request_o)
        else $error("reference requested with no user");

    // Flag, interrupt and wake checks
    a_status_clear: assert property (@(posedge clk_i) disable iff (!rst_n)
        (wr_hit && avs_byteenable_i[0] && avs_address_i == `SM_ADDR_STATUS
        && avs_writedata_i[0] && !qualified) |=> !s_reg.irq_flag)
        else $error("irq flag not cleared");
    a_set_wins: assert property (@(posedge clk_i) disable iff (!rst_n)
        (qualified && wr_hit && avs_address_i == `SM_ADDR_STATUS)
        |=> s_reg.irq_flag)
        else $error("clear beat a new event");
    a_wake_when_idle: assert property (@(posedge clk_i) disable iff (!rst_n)
        ($rose(s_reg.irq_flag) && $past(idle_i))
        |-> wake_o)
        else $error("no wake for new flag in idle");
    a_wake_only_idle: assert property (@(posedge clk_i) disable iff (!rst_n)
        wake_o
        |-> $past(idle_i))
        else $error("wake outside idle");
endmodule : supply_low_voltage_monitor

// file: testbench/supply_low_voltage_monitor_bench.sv
// Testbench for the supply low-voltage monitor
`timescale 1ns/1ps
module supply_low_voltage_monitor_bench import supply_monitor_pkg::*;;
    localparam int SD = 4;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [3:0] addr = 4'h0;
    logic rd_s = 1'b0;
    logic wr_s = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] be = 4'hF;
    logic [31:0] rdata;
    logic wait_s;
    logic cmp = 1'b0;
    logic lsr = 1'b0;
    logic slp = 1'b0;
    logic idl = 1'b0;
    logic pwr;
    logic [2:0] lvl;
    logic refq;
    logic irq;
    logic wake;
    int n_fail = 0;
    int tests_run = 0;
    int n_wake = 0;
    logic [31:0] r;

    always #2.5 clk_i = ~clk_i;
    always @(posedge clk_i) if (wake === 1'b1) n_wake <= n_wake + 1;

    supply_low_voltage_monitor #(.SUB_DIV(SD)) u_supply_low_voltage_monitor (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(addr), .avs_read_i(rd_s),
        .avs_write_i(wr_s), .avs_writedata_i(wdata), .avs_byteenable_i(be),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wait_s), .comparator_low_i(cmp),
        .low_supply_reset_enable_i(lsr), .sleep_i(slp), .idle_i(idl),
        .detector_power_o(pwr), .trip_level_o(lvl), .reference_request_o(refq),
        .irq_o(irq), .wake_o(wake)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One Avalon access, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        addr <= a;
        wr_s <= w;
        rd_s <= !w;
        wdata <= {24'h0, d};
        do
        begin
            @(posedge clk_i);
            n++;
        end while (wait_s !== 1'b0 && n < 50);
        r = rdata;
        wr_s <= 1'b0;
        rd_s <= 1'b0;
        if (n >= 50)
            n_fail++;
    endtask : bus

    task automatic rchk(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 8'h00);
        chk(r, e);
    endtask : rchk

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick

    task automatic report_and_stop;
        $display("counts: %0d mismatches, %0d comparisons", n_fail, tests_run);
        if (n_fail == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop

    initial
    begin
        tick(20000);
        n_fail++;
        report_and_stop();
    end

    initial
    begin
        int n;
        int nq;
        tick(20);
        rst_n_i <= 1'b1;
        tick(3);
        rchk(4'h0, 32'h0);
        rchk(4'h4, 32'h0);
        rchk(4'h8, 32'h0);
        bus(1'b1, 4'hC, 8'hFF);
        rchk(4'hC, 32'h0);
        be <= 4'hE;
        bus(1'b1, 4'h0, 8'hFF);
        be <= 4'hF;
        rchk(4'h0, 32'h0);
        for (int i = 0; i < 8; i++)
        begin
            bus(1'b1, 4'h0, 8'(i));
            tick(1);
            chk({29'h0, lvl}, 32'(i));
            rchk(4'h0, 32'(i));
        end
        for (int i = 0; i < 8; i++)
        begin
            lsr <= i[1];
            bus(1'b1, 4'h0, {3'h0, i[2], i[0], 3'h0});
            tick(1);
            chk({31'h0, pwr}, {31'h0, i[2]});
            chk({31'h0, refq}, {31'h0, |i[2:0]});
        end
        // Sleep overrides the enable bit
        slp <= 1'b1;
        lsr <= 1'b0;
        bus(1'b1, 4'h0, 8'h10);
        cmp <= 1'b1;
        tick(10);
        chk({31'h0, pwr}, 32'h0);
        chk({31'h0, refq}, 32'h0);
        rchk(4'h0, 32'h10);
        rchk(4'h4, 32'h0);
        slp <= 1'b0;
        cmp <= 1'b0;
        bus(1'b1, 4'h8, 8'h01);
        rchk(4'h8, 32'h1);
        for (int w = 0; w < 4; w++)
        begin
            nq = (w == 1) ? 3 : (w == 2) ? 7 : 1;
            bus(1'b1, 4'h0, {w[1:0], 6'h10});
            tick(2);
            if (nq > 1)
            begin
                cmp <= 1'b1;
                tick(2 * SD - 1);
                cmp <= 1'b0;
                tick(3);
                chk({31'h0, irq}, 32'h0);
            end
            cmp <= 1'b1;
            n = 0;
            while (irq !== 1'b1 && n < 100)
            begin
                @(posedge clk_i);
                n++;
            end
            chk(32'(n >= nq * SD && n <= (nq + 1) * SD + 3), 32'h1);
            rchk(4'h0, {24'h0, w[1:0], 6'h30});
            cmp <= 1'b0;
            tick(3);
            rchk(4'h0, {24'h0, w[1:0], 6'h10});
            rchk(4'h4, 32'h1);
            bus(1'b1, 4'h4, 8'h01);
            rchk(4'h4, 32'h0);
            chk({31'h0, irq}, 32'h0);
        end
        // Masked flag still latches but stays off the interrupt line
        bus(1'b1, 4'h8, 8'h00);
        cmp <= 1'b1;
        tick(20);
        chk({31'h0, irq}, 32'h0);
        rchk(4'h4, 32'h1);
        cmp <= 1'b0;
        bus(1'b1, 4'h4, 8'h01);
        bus(1'b1, 4'h8, 8'h01);
        idl <= 1'b1;
        cmp <= 1'b1;
        tick(20);
        chk(32'(n_wake), 32'h1);
        cmp <= 1'b0;
        tick(3);
        cmp <= 1'b1;
        tick(20);
        chk(32'(n_wake), 32'h1);
        report_and_stop();
    end
endmodule : supply_low_voltage_monitor_bench
